// File: verilog/dimp_defines.vh
// register map, field positions, reset values and scaling for the interpolating path
`ifndef DIMP_DEFINES_VH
`define DIMP_DEFINES_VH

// ==========================================
// register offsets
`define DIMP_ADDR_MAIN_CTRL   15'h0040
`define DIMP_ADDR_PD_CTRL     15'h0043
`define DIMP_ADDR_TX_CFG      15'h0060
`define DIMP_ADDR_PH_LOW      15'h0062
`define DIMP_ADDR_PH_HIGH     15'h0063
`define DIMP_ADDR_STEP_B0     15'h0064
`define DIMP_ADDR_STEP_B4     15'h0068
`define DIMP_ADDR_CODING      15'h0050
`define DIMP_ADDR_XFER        15'h0051
`define DIMP_ADDR_STATUS      15'h0052

// ==========================================
// field positions
`define DIMP_MAIN_HOLD_DIGITAL_CLOCK   0
`define DIMP_MAIN_HOLD_WCLK   1
`define DIMP_MAIN_LANE_LSB    4
`define DIMP_TX_INTERP_LSB    0
`define DIMP_TX_MOD_LSB       2
`define DIMP_PD_PIN_WAKE      0
`define DIMP_CODING_OFFSET    0
`define DIMP_XFER_REQ         0

// ==========================================
// reset values
`define DIMP_RST_MAIN_CTRL    8'h03
`define DIMP_RST_PD_CTRL      8'h01
`define DIMP_RST_TX_CFG       8'h00
`define DIMP_RST_CODING       8'h00

// ==========================================
// modulator codes
`define DIMP_MOD_POS_UPPER    3'h1
`define DIMP_MOD_POS_LOWER    3'h2
`define DIMP_MOD_NEG_UPPER    3'h3
`define DIMP_MOD_NEG_LOWER    3'h4

// ==========================================
// half-band centre tap and mixer scaling as shift counts
`define DIMP_HB1_SHIFT        16
`define DIMP_HB2_SHIFT        15
`define DIMP_HB3_SHIFT        10
`define DIMP_MIX_SHIFT        15

`endif

// File: verilog/dimp_fifo.v
// small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dimp_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             rst_n,
  // fill side
  input  wire             wr_valid,
  output wire             wr_ready,
  input  wire [WIDTH-1:0] wr_data,
  // drain side
  output wire             rd_valid,
  input  wire             rd_ready,
  output wire [WIDTH-1:0] rd_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign wr_ready = (cnt_q != DEPTH[AW:0]);
  assign rd_valid = (cnt_q != {(AW+1){1'b0}});
  assign rd_data  = mem_q[rp_q];
  assign push     = wr_valid && wr_ready;
  assign pop      = rd_valid && rd_ready;

  always @(posedge ref_clk) begin
    if (push) begin
      mem_q[wp_q] <= wr_data;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rp_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// File: verilog/dimp_path.v
// interpolating quadrature modulator path with oscillator and start-up control
// Summary of operation
// - input samples offset binary or two's complement
// - two-bit field selects interpolation factor
// - quasi-unity mode duplicates each input sample
// - first half-band stage used in all modes
// - first stage 55 taps, centre 65536
// - second stage 23 taps, centre 32768
// - third stage 15 taps, centre 1024
// - three-bit field selects modulator mode
// - sideband equations for paths A and B
// - 40-bit step word sets oscillator frequency
// - 16-bit phase word offsets oscillator phase
// - whole path runs on the digital clock
// - both clocks held in reset after reset
// - buffered registers copied at release or transfer
// - powered down, wake by pin unless cleared
`timescale 1ns/1ps
`include "dimp_defines.vh"
module dimp_path #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // register access port
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [14:0] reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  // pin
  input  wire        transmit_enable_pin,
  // samples from the clock domain interface
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [15:0] in_i,
  input  wire [15:0] in_q,
  // samples to the converter core
  output reg         out_valid,
  input  wire        out_ready,
  output reg  [15:0] out_a,
  output reg  [15:0] out_b,
  // control levels
  output wire        hold_word_clock,
  output wire        hold_digital_clock_reset,
  output wire [3:0]  lane_power_off,
  output wire        analog_powered
);
  localparam NS = 3;

  // ==========================================
  // arithmetic helpers
  function [15:0] rsat;
    input signed [47:0] v;
    input integer       sh;
    reg signed [47:0]   r;
    begin
      r = (v + (48'sh000000000001 <<< (sh - 1))) >>> sh;
      if (r > 48'sh000000007FFF) rsat = 16'h7FFF;
      else if (r < -48'sh000000008000) rsat = 16'h8000;
      else rsat = r[15:0];
    end
  endfunction

  function signed [17:0] coef;
    input integer s;
    input integer k;
    begin
      case (s * 16 + k)
        0:  coef = 18'sh0A21D;
        1:  coef = -18'sh033CA;
        2:  coef = 18'sh01C86;
        3:  coef = -18'sh011E4;
        4:  coef = 18'sh00BAB;
        5:  coef = -18'sh0079F;
        6:  coef = 18'sh004E2;
        7:  coef = -18'sh00305;
        8:  coef = 18'sh001C8;
        9:  coef = -18'sh000FC;
        10: coef = 18'sh00080;
        11: coef = -18'sh0003A;
        12: coef = 18'sh00016;
        13: coef = -18'sh00006;
        16: coef = 18'sh04F30;
        17: coef = -18'sh014EE;
        18: coef = 18'sh007C2;
        19: coef = -18'sh0028E;
        20: coef = 18'sh0009F;
        21: coef = -18'sh00015;
        32: coef = 18'sh00267;
        33: coef = -18'sh0007F;
        34: coef = 18'sh0001B;
        35: coef = -18'sh00003;
        default: coef = 18'sh00000;
      endcase
    end
  endfunction

  function [15:0] qtab;
    input [4:0] k;
    begin
      case (k)
        5'h00: qtab = 16'h0000;
        5'h01: qtab = 16'h0C8C;
        5'h02: qtab = 16'h18F9;
        5'h03: qtab = 16'h2528;
        5'h04: qtab = 16'h30FB;
        5'h05: qtab = 16'h3C56;
        5'h06: qtab = 16'h471C;
        5'h07: qtab = 16'h5133;
        5'h08: qtab = 16'h5A82;
        5'h09: qtab = 16'h62F1;
        5'h0A: qtab = 16'h6A6D;
        5'h0B: qtab = 16'h70E2;
        5'h0C: qtab = 16'h7641;
        5'h0D: qtab = 16'h7A7C;
        5'h0E: qtab = 16'h7D89;
        5'h0F: qtab = 16'h7F61;
        default: qtab = 16'h7FFF;
      endcase
    end
  endfunction

  function [15:0] sinlu;
    input [5:0] p;
    reg   [15:0] m;
    begin
      m = p[4] ? qtab(5'h10 - {1'b0, p[3:0]}) : qtab({1'b0, p[3:0]});
      if (p[4] && p[3:0] == 4'h0) m = qtab(5'h10);
      sinlu = p[5] ? (16'h0000 - m) : m;
    end
  endfunction

  // ==========================================
  // registers
  reg  [7:0]  main_q;
  reg  [7:0]  pd_q;
  reg  [7:0]  txcfg_q;
  reg  [7:0]  coding_q;
  reg         xfer_q;
  reg  [39:0] step_buf_q;
  reg  [39:0] step_act_q;
  reg  [15:0] ph_buf_q;
  reg  [15:0] ph_act_q;
  reg         hold_d1_q;
  reg         ten_s1_q;
  reg         ten_s2_q;
  wire        dp_rst;
  wire        release_ev;
  wire [1:0]  interp;
  wire [2:0]  modsel;
  integer     b;
  integer     c;

  assign hold_digital_clock_reset = main_q[`DIMP_MAIN_HOLD_DIGITAL_CLOCK];
  assign hold_word_clock          = main_q[`DIMP_MAIN_HOLD_WCLK];
  assign lane_power_off = main_q[`DIMP_MAIN_LANE_LSB +: 4];
  assign interp         = txcfg_q[`DIMP_TX_INTERP_LSB +: 2];
  assign modsel         = txcfg_q[`DIMP_TX_MOD_LSB +: 3];
  assign dp_rst         = !rst_n || hold_digital_clock_reset;
  assign release_ev     = hold_d1_q && !hold_digital_clock_reset;
  assign analog_powered = (pd_q == 8'h00) ||
                          (pd_q[`DIMP_PD_PIN_WAKE] && ten_s2_q);

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      main_q     <= `DIMP_RST_MAIN_CTRL;
      pd_q       <= `DIMP_RST_PD_CTRL;
      txcfg_q    <= `DIMP_RST_TX_CFG;
      coding_q   <= `DIMP_RST_CODING;
      xfer_q     <= 1'b0;
      step_buf_q <= 40'h0000000000;
      step_act_q <= 40'h0000000000;
      ph_buf_q   <= 16'h0000;
      ph_act_q   <= 16'h0000;
      hold_d1_q  <= 1'b1;
      ten_s1_q   <= 1'b0;
      ten_s2_q   <= 1'b0;
    end else begin
      ten_s1_q  <= transmit_enable_pin;
      ten_s2_q  <= ten_s1_q;
      hold_d1_q <= hold_digital_clock_reset;
      if (xfer_q || release_ev) begin
        step_act_q <= step_buf_q;
        ph_act_q   <= ph_buf_q;
      end
      xfer_q <= reg_wr && reg_addr == `DIMP_ADDR_XFER && reg_wdata[`DIMP_XFER_REQ];
      if (reg_wr) begin
        case (reg_addr)
          `DIMP_ADDR_MAIN_CTRL: main_q   <= reg_wdata;
          `DIMP_ADDR_PD_CTRL:   pd_q     <= reg_wdata;
          `DIMP_ADDR_TX_CFG:    txcfg_q  <= reg_wdata;
          `DIMP_ADDR_CODING:    coding_q <= reg_wdata;
          `DIMP_ADDR_PH_LOW:    ph_buf_q[7:0]  <= reg_wdata;
          `DIMP_ADDR_PH_HIGH:   ph_buf_q[15:8] <= reg_wdata;
          default: begin
            for (b = 0; b < 5; b = b + 1) begin
              if (reg_addr == `DIMP_ADDR_STEP_B0 + b[14:0]) begin
                step_buf_q[8*b +: 8] <= reg_wdata;
              end
            end
          end
        endcase
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `DIMP_ADDR_MAIN_CTRL: reg_rdata <= main_q;
        `DIMP_ADDR_PD_CTRL:   reg_rdata <= pd_q;
        `DIMP_ADDR_TX_CFG:    reg_rdata <= txcfg_q;
        `DIMP_ADDR_CODING:    reg_rdata <= coding_q;
        `DIMP_ADDR_XFER:      reg_rdata <= {7'h00, xfer_q};
        `DIMP_ADDR_STATUS:
          reg_rdata <= {4'h0, analog_powered, xfer_q, hold_word_clock,
                        hold_digital_clock_reset};
        `DIMP_ADDR_PH_LOW:    reg_rdata <= ph_buf_q[7:0];
        `DIMP_ADDR_PH_HIGH:   reg_rdata <= ph_buf_q[15:8];
        default: begin
          reg_rdata <= 8'h00;
          for (c = 0; c < 5; c = c + 1) begin
            if (reg_addr == `DIMP_ADDR_STEP_B0 + c[14:0]) begin
              reg_rdata <= step_buf_q[8*c +: 8];
            end
          end
        end
      endcase
    end
  end

  // ==========================================
  // input buffering and coding
  wire        fifo_wr_ready;
  wire [31:0] fifo_rd_data;
  wire [15:0] si_i [0:NS];
  wire [15:0] si_q [0:NS];
  wire        sv   [0:NS];
  wire        sr   [0:NS];
  wire        coding_flip;

  assign in_ready    = fifo_wr_ready && !hold_digital_clock_reset;
  assign coding_flip = coding_q[`DIMP_CODING_OFFSET];

  dimp_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .ref_clk  (ref_clk),
    .rst_n    (!dp_rst),
    .wr_valid (in_valid && !hold_digital_clock_reset),
    .wr_ready (fifo_wr_ready),
    .wr_data  ({in_i, in_q}),
    .rd_valid (sv[0]),
    .rd_ready (sr[0]),
    .rd_data  (fifo_rd_data)
  );

  // offset binary becomes two's complement by inverting the sign bit
  assign si_i[0] = fifo_rd_data[31:16] ^ {coding_flip, 15'h0000};
  assign si_q[0] = fifo_rd_data[15:0] ^ {coding_flip, 15'h0000};

  // ==========================================
  // half-band interpolation chain, two outputs per accepted input in each enabled stage
  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : stg
      localparam integer NP = (g == 0) ? 14 : (g == 1) ? 6 : 4;
      localparam integer SH = (g == 0) ? `DIMP_HB1_SHIFT :
                              (g == 1) ? `DIMP_HB2_SHIFT : `DIMP_HB3_SHIFT;
      reg  [15:0]        li_q [0:2*NP-1];
      reg  [15:0]        lq_q [0:2*NP-1];
      reg                ov_q;
      reg                ph_q;
      reg  signed [47:0] mi;
      reg  signed [47:0] mq;
      wire               en;
      wire               dup;
      wire               take;
      wire               acc;
      integer            k;
      integer            j;

      assign en   = (g == 0) || (interp > g);
      assign dup  = (g == 0) && (interp == 2'b00);
      assign take = ov_q && sr[g+1];
      assign acc  = en && sv[g] && (!ov_q || (take && ph_q));
      assign sr[g]   = en ? (!ov_q || (take && ph_q)) : sr[g+1];
      assign sv[g+1] = en ? ov_q : sv[g];

      always @* begin
        mi = 48'sh000000000000;
        mq = 48'sh000000000000;
        for (k = 0; k < NP; k = k + 1) begin
          mi = mi + coef(g, k) * ($signed({li_q[NP-1-k][15], li_q[NP-1-k]}) +
                                  $signed({li_q[NP+k][15], li_q[NP+k]}));
          mq = mq + coef(g, k) * ($signed({lq_q[NP-1-k][15], lq_q[NP-1-k]}) +
                                  $signed({lq_q[NP+k][15], lq_q[NP+k]}));
        end
      end

      assign si_i[g+1] = !en ? si_i[g] : dup ? li_q[0] :
                         ph_q ? li_q[NP-1] : rsat(mi, SH);
      assign si_q[g+1] = !en ? si_q[g] : dup ? lq_q[0] :
                         ph_q ? lq_q[NP-1] : rsat(mq, SH);

      always @(posedge ref_clk) begin
        if (dp_rst) begin
          ov_q <= 1'b0;
          ph_q <= 1'b0;
        end else if (acc) begin
          ov_q <= 1'b1;
          ph_q <= 1'b0;
        end else if (take) begin
          ov_q <= !ph_q;
          ph_q <= 1'b1;
        end
        for (j = 0; j < 2 * NP; j = j + 1) begin
          if (dp_rst) begin
            li_q[j] <= 16'h0000;
            lq_q[j] <= 16'h0000;
          end else if (acc) begin
            li_q[j] <= (j == 0) ? si_i[g] : li_q[(j == 0) ? 0 : j - 1];
            lq_q[j] <= (j == 0) ? si_q[g] : lq_q[(j == 0) ? 0 : j - 1];
          end
        end
      end
    end
  endgenerate

  // ==========================================
  // oscillator and sideband mixer
  reg  [39:0]        phacc_q;
  wire [15:0]        phase;
  wire signed [15:0] sn;
  wire signed [15:0] cs;
  wire signed [47:0] ic;
  wire signed [47:0] qs;
  wire signed [47:0] is_;
  wire signed [47:0] qc;
  wire signed [47:0] pa;
  wire signed [47:0] pb;
  wire               upper;
  wire               lower;
  wire               neg;
  wire               fire;
  wire [15:0]        a_mix;
  wire [15:0]        b_mix;

  assign phase = phacc_q[39:24] + ph_act_q;
  assign sn    = sinlu(phase[15:10]);
  assign cs    = sinlu(phase[15:10] + 6'h10);
  assign ic    = $signed(si_i[NS]) * cs;
  assign qs    = $signed(si_q[NS]) * sn;
  assign is_   = $signed(si_i[NS]) * sn;
  assign qc    = $signed(si_q[NS]) * cs;
  assign upper = (modsel == `DIMP_MOD_POS_UPPER) || (modsel == `DIMP_MOD_NEG_UPPER);
  assign lower = (modsel == `DIMP_MOD_POS_LOWER) || (modsel == `DIMP_MOD_NEG_LOWER);
  assign neg   = (modsel == `DIMP_MOD_NEG_UPPER) || (modsel == `DIMP_MOD_NEG_LOWER);
  assign pa    = upper ? (ic - qs) : (ic + qs);
  assign pb    = upper ? (is_ + qc) : (is_ - qc);
  assign a_mix = rsat(pa, `DIMP_MIX_SHIFT);
  assign b_mix = rsat(neg ? -pb : pb, `DIMP_MIX_SHIFT);
  assign fire  = sv[NS] && (!out_valid || out_ready);
  assign sr[NS] = !out_valid || out_ready;

  always @(posedge ref_clk) begin
    if (dp_rst) begin
      phacc_q   <= 40'h0000000000;
      out_valid <= 1'b0;
      out_a     <= 16'h0000;
      out_b     <= 16'h0000;
    end else begin
      if (fire) begin
        phacc_q   <= phacc_q + step_act_q;
        out_valid <= 1'b1;
        out_a     <= (upper || lower) ? a_mix : si_i[NS];
        out_b     <= (upper || lower) ? b_mix : si_q[NS];
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end
endmodule

// File: bench/dimp_path_chk_sva.sv
// port-level assertions for the interpolating modulator path
`timescale 1ns/1ps
module dimp_path_chk #(
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW    = 3
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // register port
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [14:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  // sample ports
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [15:0] out_a,
  input wire logic [15:0] out_b,
  // control levels
  input wire logic        hold_word_clock,
  input wire logic        hold_digital_clock_reset,
  input wire logic [3:0]  lane_power_off,
  input wire logic        analog_powered
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [7:0] wd_q;
  always @(posedge ref_clk) begin
    wd_q <= reg_wdata;
  end
  // ==========================================
  // sequences
  sequence s_xfer;
    reg_wr && reg_addr == 15'h0051 && reg_wdata[0];
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == 15'h0052;
  endsequence
  sequence s_main_wr;
    reg_wr && reg_addr == 15'h0040;
  endsequence
  // ==========================================
  // assertions
  a_xfer_pending_seen: assert property (s_xfer ##1 s_stat_rd |=> reg_rdata[2])
    else $error("transfer request not pending on status read");
  a_status_bits: assert property (s_stat_rd |=>
    reg_rdata[1:0] == $past({hold_word_clock, hold_digital_clock_reset})
    && reg_rdata[3] == $past(analog_powered))
    else $error("status read disagrees with control levels");
  a_main_read: assert property (reg_rd && reg_addr == 15'h0040 |=>
    reg_rdata[1:0] == $past({hold_word_clock, hold_digital_clock_reset})
    && reg_rdata[7:4] == $past(lane_power_off))
    else $error("main control read disagrees with levels");
  a_reset_holds: assert property ($rose(rst_n) |->
    hold_digital_clock_reset && hold_word_clock && !in_ready)
    else $error("clocks not held after reset");
  a_hold_blocks: assert property (hold_digital_clock_reset |-> !in_ready)
    else $error("samples accepted while held");
  a_hold_quiet: assert property (hold_digital_clock_reset |=> !out_valid)
    else $error("output sample while held");
  a_main_write: assert property (s_main_wr |=> hold_digital_clock_reset == wd_q[0]
    && hold_word_clock == wd_q[1] && lane_power_off == wd_q[7:4])
    else $error("main control write not applied");
  a_out_held: assert property (out_valid && !out_ready && !hold_digital_clock_reset
    |=> out_valid && $stable(out_a) && $stable(out_b))
    else $error("output changed while stalled");
  a_pd_clear: assert property (reg_wr && reg_addr == 15'h0043 && reg_wdata == 8'h00
    |=> analog_powered)
    else $error("power-down clear did not wake");
endmodule
bind dimp_path dimp_path_chk #(.FIFO_DEPTH(FIFO_DEPTH), .FIFO_AW(FIFO_AW)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .in_ready(in_ready), .out_valid(out_valid), .out_ready(out_ready),
  .out_a(out_a), .out_b(out_b), .hold_word_clock(hold_word_clock),
  .hold_digital_clock_reset(hold_digital_clock_reset),
  .lane_power_off(lane_power_off), .analog_powered(analog_powered));

// File: bench/dimp_lane_src.sv
// lane processing side model: offers I/Q samples with valid/ready
`timescale 1ns/1ps
module dimp_lane_src (
  // clock
  input  wire logic        ref_clk,
  // command from the bench
  input  wire logic        start,
  input  wire logic [15:0] cnt,
  input  wire logic [15:0] i_val,
  input  wire logic [15:0] q_val,
  // sample interface
  output logic             in_valid,
  input  wire logic        in_ready,
  output logic [15:0]      in_i,
  output logic [15:0]      in_q,
  output logic             busy
);
  int   left;
  logic ld;
  initial begin
    in_valid = 1'b0;
    in_i = 16'h0000;
    in_q = 16'h0000;
    busy = 1'b0;
    left = 0;
  end
  always @(posedge ref_clk) begin
    ld = start;
    if (in_valid && in_ready) left--;
    #1;
    if (ld) left = cnt;
    in_valid = left > 0;
    busy = left > 0;
    // idle lines are not driven by the link: show a moving pattern
    in_i = in_valid ? i_val : ~in_i;
    in_q = in_valid ? q_val : ~in_q;
  end
endmodule

// File: bench/dimp_path_tb.sv
// self-checking bench for the interpolating modulator path
`timescale 1ns/1ps
`include "dimp_defines.vh"
module dimp_path_tb;
  logic        ref_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, pin = 0;
  logic        out_ready = 1, stall = 0, block = 0, start = 0;
  logic [14:0] reg_addr = 15'h0;
  logic [7:0]  reg_wdata = 8'h00, rd;
  logic [15:0] n = 16'h0, si = 16'h0, sq = 16'h0, qa[$], qb[$];
  wire         in_valid, in_ready, out_valid, hold_w, hold_d, apow, busy;
  wire  [15:0] in_i, in_q, out_a, out_b;
  wire  [7:0]  reg_rdata;
  wire  [3:0]  lpo;
  int          errors = 0, check_count = 0;
  always #2 ref_clk = ~ref_clk;
  dimp_path #(.FIFO_DEPTH(8), .FIFO_AW(3)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .transmit_enable_pin(pin), .in_valid(in_valid),
    .in_ready(in_ready), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
    .out_ready(out_ready), .out_a(out_a), .out_b(out_b), .hold_word_clock(hold_w),
    .hold_digital_clock_reset(hold_d), .lane_power_off(lpo), .analog_powered(apow));
  dimp_lane_src u_src (.ref_clk(ref_clk), .start(start), .cnt(n), .i_val(si),
    .q_val(sq), .in_valid(in_valid), .in_ready(in_ready), .in_i(in_i), .in_q(in_q),
    .busy(busy));
  // ==========================================
  // converter side: capture and stall
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready === 1'b1) begin
      qa.push_back(out_a);
      qb.push_back(out_b);
    end
    #1 out_ready = block ? 1'b0 : (stall ? ~out_ready : 1'b1);
  end
  // ==========================================
  // helpers
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [14:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    tick(1);
  endtask
  task automatic rdr(logic [14:0] a);
    reg_addr = a;
    reg_rd = 1;
    tick(1);
    reg_rd = 0;
    rd = reg_rdata;
    tick(1);
  endtask
  task automatic restart;
    wr(`DIMP_ADDR_MAIN_CTRL, 8'h03);
    wr(`DIMP_ADDR_MAIN_CTRL, 8'h00);
  endtask
  task automatic wait_out(int exp);
    for (int k = 0; k < 4000 && qa.size() < exp; k++) @(posedge ref_clk);
    tick(30);
    chk("out_count", qa.size(), exp);
  endtask
  task automatic run(int cnt, logic [15:0] i, logic [15:0] q, int exp);
    qa.delete();
    qb.delete();
    n = cnt;
    si = i;
    sq = q;
    start = 1;
    tick(1);
    start = 0;
    wait_out(exp);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    rdr(`DIMP_ADDR_MAIN_CTRL);  chk("main_rst", rd, 8'h03);
    rdr(`DIMP_ADDR_PD_CTRL);    chk("pd_rst", rd, 8'h01);
    rdr(`DIMP_ADDR_TX_CFG);     chk("tx_rst", rd, 8'h00);
    rdr(`DIMP_ADDR_CODING);     chk("coding_rst", rd, 8'h00);
    rdr(15'h7FFF);              chk("unmapped", rd, 8'h00);
    chk("ready_held", in_ready, 0);
    chk("asleep", apow, 0);
    pin = 1;
    tick(4);
    chk("pin_wake", apow, 1);
    pin = 0;
  endtask
  task automatic t_config;
    wr(15'h0000, 8'h99);
    wr(`DIMP_ADDR_PD_CTRL, 8'h00);
    wr(`DIMP_ADDR_TX_CFG, 8'h00);
    wr(15'h0022, 8'h22);
    wr(15'h0022, 8'h44);
    rdr(`DIMP_ADDR_STATUS);
    chk("status", rd, 8'h0B);
    wr(`DIMP_ADDR_MAIN_CTRL, 8'h00);
    chk("released", {hold_w, hold_d, lpo}, 0);
    chk("awake", apow, 1);
  endtask
  task automatic t_interp;
    stall = 1;
    for (int m = 0; m < 4; m++) begin
      wr(`DIMP_ADDR_TX_CFG, m[7:0]);
      restart();
      run(40, 16'h1234, 16'hF000, (m == 0) ? 80 : (40 << m));
      chk("dc_a", qa[qa.size()-1], 16'h1234);
      chk("dc_b", qb[qb.size()-1], 16'hF000);
    end
    stall = 0;
  endtask
  task automatic t_mod;
    wr(`DIMP_ADDR_CODING, 8'h01);
    wr(`DIMP_ADDR_TX_CFG, 8'h00);
    restart();
    run(2, 16'h9000, 16'h7000, 4);
    chk("ofs_a", qa[3], 16'h1000);
    chk("ofs_b", qb[3], 16'hF000);
    wr(`DIMP_ADDR_CODING, 8'h00);
    for (int md = 1; md < 5; md++) begin
      wr(`DIMP_ADDR_TX_CFG, 8'(md << 2));
      restart();
      run(2, 16'h1000, 16'h0800, 4);
      chk("mix_a", qa[3], 16'h1000);
      chk("mix_b", qb[3], (md == 2 || md == 3) ? 16'hF800 : 16'h0800);
    end
  endtask
  task automatic t_phase;
    wr(`DIMP_ADDR_PH_HIGH, 8'h40);
    run(2, 16'h1000, 16'h0800, 4);
    chk("ph_buffered", qa[3], 16'h1000);
    reg_addr = `DIMP_ADDR_XFER;
    reg_wdata = 8'h01;
    reg_wr = 1;
    tick(1);
    reg_wr = 0;
    reg_rd = 1;
    reg_addr = `DIMP_ADDR_STATUS;
    tick(1);
    reg_rd = 0;
    chk("xfer_pending", reg_rdata[2], 1);
    tick(2);
    run(2, 16'h1000, 16'h0800, 4);
    chk("ph_a", qa[3], 16'h0800);
    chk("ph_b", qb[3], 16'hF000);
    wr(`DIMP_ADDR_PH_HIGH, 8'h00);
  endtask
  task automatic t_step;
    wr(`DIMP_ADDR_STEP_B4, 8'h80);
    restart();
    run(8, 16'h1000, 16'h0000, 16);
    for (int k = 1; k < 16; k++) begin
      chk("half_turn", qa[k] + qa[k-1], 16'h0000);
      chk("mag", qa[k] == 16'h1000 || qa[k] == 16'hF000, 1);
    end
    wr(`DIMP_ADDR_STEP_B4, 8'h00);
    wr(`DIMP_ADDR_TX_CFG, 8'h00);
    restart();
  endtask
  task automatic t_fifo;
    block = 1;
    qa.delete();
    n = 20;
    si = 16'h0001;
    sq = 16'h0002;
    start = 1;
    tick(1);
    start = 0;
    tick(40);
    chk("full_refused", {in_ready, busy}, 16'h0001);
    block = 0;
    wait_out(40);
    chk("drained", {in_ready, busy}, 16'h0002);
    chk("fifo_last", qa[39], 16'h0001);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    tick(3);
    rst_n = 1;
    tick(10);
    t_reset();
    t_config();
    t_interp();
    t_mod();
    t_phase();
    t_step();
    t_fifo();
    end_sim();
  end
  initial begin
    #200000;
    errors++;
    end_sim();
  end
endmodule
